// File: smf_host.sv
// host controller model driving the serial link of the register bank
`timescale 1ns/1ps
module smf_host (
    // serial link
    output logic link_sck,
    output logic link_csb_n,
    output logic link_sdi,
    input wire logic link_sdo,
    input wire logic link_sdo_oe
);
    initial begin
        link_sck = 1'b0;
        link_csb_n = 1'b1;
        link_sdi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // host side reading of an external temperature code, in millivolts
    function automatic real temp_mv(input logic [11:0] code);
        return code * 1.5;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // one frame: command, nw bytes from wd (first byte on top), then nr bytes read
    task automatic frame(input logic [7:0] cmd, input logic [47:0] wd, input int nw,
                         input int nr, output logic [63:0] rd, output logic [63:0] oe);
        logic [103:0] tx;
        tx = {cmd, wd, 48'h0};
        rd = '0;
        oe = '0;
        link_csb_n = 1'b0;
        // sck stands still until the snapshot has been frozen
        #150;
        for (int i = 0; i < 8 + 8 * (nw + nr); i++) begin
            // unused data bits toggle so a stale level never looks valid
            link_sdi = (i < 8 + 8 * nw) ? tx[103 - i] : ~link_sdi;
            #7.5;
            if (i >= 8 + 8 * nw) begin
                rd = {rd[62:0], link_sdo};
                oe = {oe[62:0], link_sdo_oe};
            end
            link_sck = 1'b1;
            #7.5;
            link_sck = 1'b0;
        end
        #7.5;
        link_csb_n = 1'b1;
        // idle gap between frames
        #200;
    endtask
endmodule

// File: smf_pkg.sv
// types shared by the stack monitor register bank
package smf_pkg;
    typedef enum logic [1:0] {LK_CMD, LK_WRITE, LK_READ, LK_IDLE} smf_link_e;
    typedef logic [2:0] smf_cdc_t;
    typedef logic [7:0] smf_byte_t;
    typedef logic [11:0] smf_code_t;
endpackage

// File: smf_regs.sv
// stack monitor flag, temperature and configuration register bank
`timescale 1ns/1ps
`include "smf_regs.svh"

// Overview of operation
// - Three read-only flag bytes cover four cells each, undervoltage in the even bit, overvoltage in the odd bit above.
// - In ten-cell mode the flags of cells 11 and 12 in the third flag byte read as zero.
// - Two external and one internal 12-bit temperature results pack low bits first into five bytes, with revision in 7:5 and thermal shutdown in bit 4 of the last.
// - A packet check byte follows the data bytes of every group read.
// - Duty-cycle value 0 is standby: comparator off, reference down, no measurement time.
// - Values 1 to 4 keep the reference on with 13ms measurement; the comparator is off at 1 and runs every 13, 130 or 500ms at 2, 3, 4.
// - While the measure-mode pin is low the duty-cycle value 5 is used whatever was written.
// - The cell-count bit selects twelve cells at 0 (default) and ten cells at 1.
// - The polling-style bit selects toggle polling at 0 (default) and level polling at 1.
// - Writing 0 to a general pin bit turns its pull-down on, 1 (default) turns it off.
// - Reading a general pin bit returns the pin level, not the written value.
// - The watchdog bit is read-only and returns the watchdog output pin level.
// - Reading the temperature group clears the thermal shutdown status.
// - At each comparator tick a cell overvoltage flag is set when its voltage exceeds the overvoltage level and cleared otherwise.
module smf_regs
    import smf_pkg::*;
#(
    parameter int unsigned P_MEAS_FAST = `SMF_T_MEAS_FAST_MS * `SMF_MCLK_KHZ,
    parameter int unsigned P_MEAS_SLOW = `SMF_T_MEAS_SLOW_MS * `SMF_MCLK_KHZ,
    parameter int unsigned P_CMP_13 = `SMF_T_CMP_13_MS * `SMF_MCLK_KHZ,
    parameter int unsigned P_CMP_130 = `SMF_T_CMP_130_MS * `SMF_MCLK_KHZ,
    parameter int unsigned P_CMP_500 = `SMF_T_CMP_500_MS * `SMF_MCLK_KHZ,
    parameter int unsigned P_CMP_2000 = `SMF_T_CMP_2000_MS * `SMF_MCLK_KHZ,
    parameter logic [7:0] FACTORY_UV_THR = 8'h40,
    parameter logic [7:0] FACTORY_OV_THR = 8'h90,
    // arbitrary value
    parameter logic [2:0] REVISION = 3'h2
) (
    // system
    input wire logic mclk,
    input wire logic reset,
    // serial link
    input wire logic link_sck,
    input wire logic link_csb_n,
    input wire logic link_sdi,
    output logic link_sdo,
    output logic link_sdo_oe,
    // measurement results, mclk domain
    input wire logic [143:0] cell_voltage_codes,
    input wire logic temp_done,
    input wire smf_code_t external_temp_one,
    input wire smf_code_t external_temp_two,
    input wire smf_code_t internal_temp,
    // pins
    input wire logic measure_mode_select_pin_n,
    input wire logic general_pin_one_level,
    input wire logic general_pin_two_level,
    input wire logic watchdog_output_pin,
    input wire logic thermal_shutdown_event,
    // control outputs
    output logic general_pin_one_pulldown_en,
    output logic general_pin_two_pulldown_en,
    output logic reference_on,
    output logic comparator_on,
    output logic comparator_tick,
    output logic [31:0] meas_time_cycles,
    output logic ten_cell_select,
    output logic polling_style_select
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [2:0] csb_sync_q;
    logic [4:0] pin_m1_q;
    logic [4:0] pin_m2_q;
    logic [1:0] wrv_sync_q;
    logic [1:0] rdt_sync_q;
    logic csb_rise;
    logic frame_seen_q;
    logic apply;
    logic mmb_low;
    logic thermal_s;
    smf_cdc_t cdc_eff;
    smf_byte_t cfg_q [6];
    smf_byte_t live [14];
    smf_byte_t snap_q [14];
    logic [11:0] uv_q;
    logic [11:0] ov_q;
    logic [11:0] uv_now;
    logic [11:0] ov_now;
    logic [7:0] uv_thr;
    logic [7:0] ov_thr;
    logic thermal_shutdown_status_q;
    logic thermal_shutdown_status_clr;
    smf_code_t et1_q;
    smf_code_t et2_q;
    smf_code_t it_q;
    logic [31:0] period;
    logic [31:0] cnt_q;
    logic cmp_run;
    logic cmp_tick;
    logic ref_on_q;
    logic cmp_on_q;
    logic tick_q;
    logic [31:0] meas_q;
    // link side
    smf_link_e phase_q;
    logic [2:0] bit_cnt_q;
    logic [2:0] wr_idx_q;
    logic [3:0] rd_idx_q;
    logic [3:0] rd_end_q;
    smf_byte_t shin_q;
    smf_byte_t out_q;
    smf_byte_t crc_q;
    smf_byte_t crc_nx;
    smf_byte_t byte_in;
    logic byte_done;
    logic oe_q;
    logic pec_q;
    smf_byte_t wr_hold_q [6];
    logic wr_valid_q;
    logic rd_tmp_q;

    function automatic smf_byte_t crc_step(input smf_byte_t crc, input logic din);
        logic fb;
        fb = crc[7] ^ din;
        crc_step = {crc[6:0], 1'b0} ^ (fb ? `SMF_PEC_POLY : 8'h00);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // synchronisers
    always_ff @(posedge mclk) begin
        if (reset) begin
            csb_sync_q <= 3'h7;
            pin_m1_q <= 5'h01;
            pin_m2_q <= 5'h01;
            wrv_sync_q <= 2'h0;
            rdt_sync_q <= 2'h0;
        end else begin
            csb_sync_q <= {csb_sync_q[1:0], link_csb_n};
            pin_m1_q <= {thermal_shutdown_event, watchdog_output_pin, general_pin_two_level,
                         general_pin_one_level, measure_mode_select_pin_n};
            pin_m2_q <= pin_m1_q;
            wrv_sync_q <= {wrv_sync_q[0], wr_valid_q};
            rdt_sync_q <= {rdt_sync_q[0], rd_tmp_q};
        end
    end

    assign csb_rise = csb_sync_q[1] & ~csb_sync_q[2];
    assign mmb_low = ~pin_m2_q[0];
    assign thermal_s = pin_m2_q[4];

    // sck holds still outside frames, so the link flags settle before the frame end is seen
    always_ff @(posedge mclk) begin
        if (reset) begin
            frame_seen_q <= 1'b0;
        end else if (!csb_sync_q[1]) begin
            frame_seen_q <= 1'b1;
        end
    end

    assign apply = csb_rise & frame_seen_q;

    ////////////////////////////////////////////////////////////////////////////////
    // configuration bytes
    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_q[0] <= `SMF_CFG0_RST;
            for (int i = 1; i < 6; i++) begin
                cfg_q[i] <= `SMF_CFGX_RST;
            end
        end else if (apply && wrv_sync_q[1]) begin
            for (int i = 0; i < 6; i++) begin
                cfg_q[i] <= wr_hold_q[i];
            end
        end
    end

    assign cdc_eff = mmb_low ? `SMF_CDC_MMB : cfg_q[0][`SMF_CFG0_CDC_MSB:0];
    assign ten_cell_select = cfg_q[0][`SMF_CFG0_TEN_CELL];
    assign polling_style_select = cfg_q[0][`SMF_CFG0_POLL_STYLE];
    assign general_pin_one_pulldown_en = ~cfg_q[0][`SMF_CFG0_GPIN_ONE];
    assign general_pin_two_pulldown_en = ~cfg_q[0][`SMF_CFG0_GPIN_TWO];

    ////////////////////////////////////////////////////////////////////////////////
    // duty cycle, reference and comparator timing
    always_comb begin
        case (cdc_eff)
            3'h2: period = P_CMP_13;
            3'h3: period = P_CMP_130;
            3'h4: period = P_CMP_500;
            3'h5: period = P_CMP_130;
            3'h6: period = P_CMP_500;
            3'h7: period = P_CMP_2000;
            default: period = 32'h0;
        endcase
    end

    assign cmp_run = cdc_eff >= `SMF_CDC_CMP_FIRST;
    // >= keeps the tick alive when software shortens the period mid-count
    assign cmp_tick = cmp_run && (cnt_q >= period - 32'h1);

    always_ff @(posedge mclk) begin
        if (reset || !cmp_run) begin
            cnt_q <= 32'h0;
        end else if (cmp_tick) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ref_on_q <= 1'b0;
            cmp_on_q <= 1'b0;
            tick_q <= 1'b0;
            meas_q <= 32'h0;
        end else begin
            ref_on_q <= (cdc_eff != `SMF_CDC_STANDBY) && (cdc_eff <= `SMF_CDC_REF_LAST);
            cmp_on_q <= cmp_run;
            tick_q <= cmp_tick;
            if (cdc_eff == `SMF_CDC_STANDBY) begin
                meas_q <= 32'h0;
            end else if (cdc_eff <= `SMF_CDC_REF_LAST) begin
                meas_q <= P_MEAS_FAST;
            end else begin
                meas_q <= P_MEAS_SLOW;
            end
        end
    end

    assign reference_on = ref_on_q;
    assign comparator_on = cmp_on_q;
    assign comparator_tick = tick_q;
    assign meas_time_cycles = meas_q;

    ////////////////////////////////////////////////////////////////////////////////
    // cell comparators and flags
    assign uv_thr = mmb_low ? FACTORY_UV_THR : cfg_q[4];
    assign ov_thr = mmb_low ? FACTORY_OV_THR : cfg_q[5];

    for (genvar g = 0; g < 12; g++) begin : g_cmp
        assign ov_now[g] = cell_voltage_codes[12*g +: 12] > {ov_thr, 4'h0};
        assign uv_now[g] = cell_voltage_codes[12*g +: 12] < {uv_thr, 4'h0};
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            uv_q <= 12'h000;
            ov_q <= 12'h000;
        end else if (cmp_tick) begin
            uv_q <= uv_now;
            ov_q <= ov_now;
        end
    end

    a_flags_hold: assert property (@(posedge mclk) disable iff (reset)
        !cmp_tick |=> $stable(ov_q) && $stable(uv_q))
        else $error("flags changed outside a comparator tick");
    a_flags_update: assert property (@(posedge mclk) disable iff (reset)
        cmp_tick |=> ov_q == $past(ov_now) && uv_q == $past(uv_now))
        else $error("flags not taken at comparator tick");

    ////////////////////////////////////////////////////////////////////////////////
    // temperatures and thermal shutdown
    always_ff @(posedge mclk) begin
        if (reset) begin
            et1_q <= 12'h000;
            et2_q <= 12'h000;
            it_q <= 12'h000;
        end else if (temp_done) begin
            et1_q <= external_temp_one;
            et2_q <= external_temp_two;
            it_q <= internal_temp;
        end
    end

    assign thermal_shutdown_status_clr = apply & rdt_sync_q[1];

    // a shutdown still present at the clear keeps the bit set
    always_ff @(posedge mclk) begin
        if (reset) begin
            thermal_shutdown_status_q <= 1'b0;
        end else begin
            thermal_shutdown_status_q <= thermal_s | (thermal_shutdown_status_q & ~thermal_shutdown_status_clr);
        end
    end

    a_thermal_shutdown_status_clear: assert property (@(posedge mclk) disable iff (reset)
        thermal_shutdown_status_clr && !thermal_s |=> !thermal_shutdown_status_q)
        else $error("thermal status not cleared by temperature read");

    ////////////////////////////////////////////////////////////////////////////////
    // read image, frozen while a frame is open
    always_comb begin
        live[0] = {pin_m2_q[3], pin_m2_q[2], pin_m2_q[1], cfg_q[0][4:0]};
        for (int i = 1; i < 6; i++) begin
            live[i] = cfg_q[i];
        end
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 4; j++) begin
                live[6+k][2*j] = uv_q[4*k+j];
                live[6+k][2*j+1] = ov_q[4*k+j];
            end
        end
        if (ten_cell_select) begin
            live[8][7:4] = 4'h0;
        end
        live[9] = et1_q[7:0];
        live[10] = {et2_q[3:0], et1_q[11:8]};
        live[11] = et2_q[11:4];
        live[12] = it_q[7:0];
        live[13] = {REVISION, thermal_shutdown_status_q, it_q[11:8]};
    end

    // the image may still move in the first mclk cycles of a frame; the command byte covers it
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i < 14; i++) begin
                snap_q[i] <= 8'h00;
            end
        end else if (csb_sync_q[1]) begin
            for (int i = 0; i < 14; i++) begin
                snap_q[i] <= live[i];
            end
        end
    end

    a_ten_cell: assert property (@(posedge mclk) disable iff (reset)
        ten_cell_select |-> live[8][7:4] == 4'h0)
        else $error("cells 11 and 12 flagged in ten-cell mode");
    a_mmb_force: assert property (@(posedge mclk) disable iff (reset)
        !pin_m2_q[0] |-> cdc_eff == 3'h5)
        else $error("measure-mode pin low but duty cycle not 5");
    a_standby: assert property (@(posedge mclk) disable iff (reset)
        cdc_eff == 3'h0 |=> !reference_on && !comparator_on && meas_time_cycles == 32'h0)
        else $error("standby not entered at duty cycle 0");
    a_slow_mode: assert property (@(posedge mclk) disable iff (reset)
        cdc_eff >= 3'h5 |=> !reference_on && comparator_on && meas_time_cycles == P_MEAS_SLOW)
        else $error("slow duty cycle settings wrong");
    a_pin_readback: assert property (@(posedge mclk) disable iff (reset)
        csb_sync_q[1] |=> snap_q[0][7:5] == $past(pin_m2_q[3:1]))
        else $error("pin readback does not follow pin levels");

    ////////////////////////////////////////////////////////////////////////////////
    // serial link, sck domain, frame state cleared while chip select is high
    assign byte_in = {shin_q[6:0], link_sdi};
    assign byte_done = bit_cnt_q == 3'h7;
    assign crc_nx = crc_step(crc_q, out_q[7]);

    always_ff @(posedge link_sck or posedge link_csb_n) begin
        if (link_csb_n) begin
            phase_q <= LK_CMD;
            bit_cnt_q <= 3'h0;
            wr_idx_q <= 3'h0;
            rd_idx_q <= 4'h0;
            rd_end_q <= 4'h0;
            shin_q <= 8'h00;
            out_q <= 8'h00;
            crc_q <= `SMF_PEC_INIT;
            oe_q <= 1'b0;
            pec_q <= 1'b0;
        end else begin
            shin_q <= byte_in;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            case (phase_q)
                LK_CMD: begin
                    if (byte_done) begin
                        case (byte_in)
                            `SMF_CMD_RDCFG: begin
                                phase_q <= LK_READ;
                                rd_idx_q <= `SMF_CFG_FIRST;
                                rd_end_q <= `SMF_CFG_LAST;
                                out_q <= snap_q[`SMF_CFG_FIRST];
                                oe_q <= 1'b1;
                            end
                            `SMF_CMD_RDFLG: begin
                                phase_q <= LK_READ;
                                rd_idx_q <= `SMF_FLG_FIRST;
                                rd_end_q <= `SMF_FLG_LAST;
                                out_q <= snap_q[`SMF_FLG_FIRST];
                                oe_q <= 1'b1;
                            end
                            `SMF_CMD_RDTMP: begin
                                phase_q <= LK_READ;
                                rd_idx_q <= `SMF_TMP_FIRST;
                                rd_end_q <= `SMF_TMP_LAST;
                                out_q <= snap_q[`SMF_TMP_FIRST];
                                oe_q <= 1'b1;
                            end
                            `SMF_CMD_WRCFG: phase_q <= LK_WRITE;
                            default: phase_q <= LK_IDLE;
                        endcase
                    end
                end
                LK_READ: begin
                    out_q <= {out_q[6:0], 1'b0};
                    if (!pec_q) begin
                        crc_q <= crc_nx;
                    end
                    if (byte_done) begin
                        if (pec_q) begin
                            phase_q <= LK_IDLE;
                            oe_q <= 1'b0;
                            pec_q <= 1'b0;
                            out_q <= 8'h00;
                        end else if (rd_idx_q == rd_end_q) begin
                            out_q <= crc_nx;
                            pec_q <= 1'b1;
                        end else begin
                            rd_idx_q <= rd_idx_q + 4'h1;
                            out_q <= snap_q[rd_idx_q + 4'h1];
                        end
                    end
                end
                LK_WRITE: begin
                    if (byte_done) begin
                        wr_idx_q <= wr_idx_q + 3'h1;
                        if (wr_idx_q == `SMF_WR_LAST) begin
                            phase_q <= LK_IDLE;
                        end
                    end
                end
                default: begin
                    oe_q <= 1'b0;
                end
            endcase
        end
    end

    // kept across the frame end so the mclk side can pick them up afterwards
    always_ff @(posedge link_sck) begin
        if (phase_q == LK_CMD && bit_cnt_q == 3'h0) begin
            wr_valid_q <= 1'b0;
            rd_tmp_q <= 1'b0;
        end
        if (phase_q == LK_CMD && byte_done && byte_in == `SMF_CMD_RDTMP) begin
            rd_tmp_q <= 1'b1;
        end
        if (phase_q == LK_WRITE && byte_done) begin
            wr_hold_q[wr_idx_q] <= byte_in;
            if (wr_idx_q == `SMF_WR_LAST) begin
                wr_valid_q <= 1'b1;
            end
        end
    end

    assign link_sdo = out_q[7] & oe_q;
    assign link_sdo_oe = oe_q;

endmodule

// File: smf_regs.svh
// constants for the stack monitor flag, temperature and configuration bank
`ifndef SMF_REGS_SVH
`define SMF_REGS_SVH

// serial command codes
`define SMF_CMD_WRCFG 8'h01
`define SMF_CMD_RDCFG 8'h02
`define SMF_CMD_RDFLG 8'h06
`define SMF_CMD_RDTMP 8'h08

// positions of each group inside the read snapshot (first and last byte)
`define SMF_CFG_FIRST 4'h0
`define SMF_CFG_LAST 4'h5
`define SMF_FLG_FIRST 4'h6
`define SMF_FLG_LAST 4'h8
`define SMF_TMP_FIRST 4'h9
`define SMF_TMP_LAST 4'hd
`define SMF_WR_LAST 3'h5

// first configuration byte fields
`define SMF_CFG0_CDC_MSB 2
`define SMF_CFG0_TEN_CELL 3
`define SMF_CFG0_POLL_STYLE 4
`define SMF_CFG0_GPIN_ONE 5
`define SMF_CFG0_GPIN_TWO 6
`define SMF_CFG0_WATCHDOG 7

// reset values
`define SMF_CFG0_RST 8'h60
`define SMF_CFGX_RST 8'h00

// duty cycle codes
`define SMF_CDC_STANDBY 3'h0
`define SMF_CDC_REF_LAST 3'h4
`define SMF_CDC_CMP_FIRST 3'h2
`define SMF_CDC_MMB 3'h5

// packet check code
`define SMF_PEC_POLY 8'h07
`define SMF_PEC_INIT 8'h41

// timing
`define SMF_MCLK_KHZ 25000
`define SMF_T_MEAS_FAST_MS 13
`define SMF_T_MEAS_SLOW_MS 21
`define SMF_T_CMP_13_MS 13
`define SMF_T_CMP_130_MS 130
`define SMF_T_CMP_500_MS 500
`define SMF_T_CMP_2000_MS 2000

`endif

// File: tb_smf_regs.sv
// testbench for the stack monitor flag, temperature and configuration bank
`timescale 1ns/1ps
`include "smf_regs.svh"
module tb_smf_regs;
    import smf_pkg::*;
    localparam logic [2:0] revision_code = 3'h5; // arbitrary value
    localparam logic [39:0] cfg_tail = 40'ha53c0f4090;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic link_sck, link_csb_n, link_sdi, link_sdo, link_sdo_oe;
    logic [143:0] cell_voltage_codes = '0;
    logic temp_done = 1'b0;
    smf_code_t ext1 = '0, ext2 = '0, intl = '0;
    logic mm_n = 1'b1, gp1 = 1'b1, gp2 = 1'b0, watch_pin = 1'b1, hot_ev = 1'b0;
    logic gp1_pd, gp2_pd, ref_on, cmp_on, tick, ten_cell, poll_style;
    logic [31:0] meas;
    logic [63:0] rd, oe;
    logic [23:0] fl;
    int bad_count = 0;
    int num_checks = 0;
    int gap;
    int per[8] = '{0, 0, 20, 40, 60, 40, 60, 80};
    logic [11:0] codes[12] = '{12'h3ff, 12'h400, 12'h900, 12'h901, 12'hfff, 12'h000,
                               12'h800, 12'h901, 12'h3ff, 12'h901, 12'h000, 12'hfff};

    always #20 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    // small counts keep the comparator periods short
    // the fast measurement time keeps its real count: it sets no waiting period in the bench
    smf_regs #(.P_MEAS_SLOW(15), .P_CMP_13(20), .P_CMP_130(40),
               .P_CMP_500(60), .P_CMP_2000(80), .REVISION(revision_code)) i_dut (
        .mclk(mclk), .reset(reset), .link_sck(link_sck), .link_csb_n(link_csb_n),
        .link_sdi(link_sdi), .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe),
        .cell_voltage_codes(cell_voltage_codes), .temp_done(temp_done),
        .external_temp_one(ext1), .external_temp_two(ext2), .internal_temp(intl),
        .measure_mode_select_pin_n(mm_n), .general_pin_one_level(gp1),
        .general_pin_two_level(gp2), .watchdog_output_pin(watch_pin),
        .thermal_shutdown_event(hot_ev), .general_pin_one_pulldown_en(gp1_pd),
        .general_pin_two_pulldown_en(gp2_pd), .reference_on(ref_on),
        .comparator_on(cmp_on), .comparator_tick(tick), .meas_time_cycles(meas),
        .ten_cell_select(ten_cell), .polling_style_select(poll_style));

    smf_host i_host (.link_sck(link_sck), .link_csb_n(link_csb_n), .link_sdi(link_sdi),
                     .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] crc(input logic [63:0] d, input int n);
        logic [7:0] c;
        c = `SMF_PEC_INIT;
        for (int i = n * 8 - 1; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `SMF_PEC_POLY : 8'h00);
        end
        return c;
    endfunction

    // one byte past the check byte shows the device has let go of the line
    task automatic rdchk(input logic [7:0] cmd, input int nd, input logic [63:0] exp);
        i_host.frame(cmd, 48'h0, 0, nd + 2, rd, oe);
        chk(rd >> 16, exp);
        chk(rd[15:0], {crc(exp, nd), 8'h00});
        chk(oe, (64'h1 << (8 * nd + 16)) - 64'h100);
    endtask

    task automatic wr(input logic [47:0] v);
        i_host.frame(`SMF_CMD_WRCFG, v, 6, 0, rd, oe);
        @(negedge mclk);
    endtask

    // first pass may start mid period, second one measures a full period
    task automatic tick_gap();
        repeat (2) begin
            gap = 0;
            do begin
                @(negedge mclk);
                gap++;
            end while (tick !== 1'b1 && gap < 300);
        end
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1000000;
        bad_count++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(negedge mclk);
        chk({ref_on, cmp_on, meas, gp2_pd, gp1_pd, ten_cell, poll_style}, '0);
        rdchk(`SMF_CMD_RDCFG, 6, {8'ha0, 40'h0});
        for (int d = 0; d < 8; d++) begin
            wr({3'b010, d[0], d[1], d[2:0], cfg_tail});
            chk(ref_on, d >= 1 && d <= 4);
            chk(cmp_on, d >= 2);
            chk(meas, d == 0 ? 0 : (d <= 4 ? `SMF_T_MEAS_FAST_MS * `SMF_MCLK_KHZ : 15));
            chk({ten_cell, poll_style}, {d[1], d[0]});
            chk({gp2_pd, gp1_pd}, 2'b01);
            if (d >= 2) begin
                tick_gap();
                chk(gap, per[d]);
            end
        end
        rdchk(`SMF_CMD_RDCFG, 6, {8'hbf, cfg_tail});
        wr({8'h61, cfg_tail});
        @(posedge mclk);
        mm_n <= 1'b0;
        repeat (4) @(negedge mclk);
        chk({ref_on, cmp_on, meas}, {2'b01, 32'd15});
        tick_gap();
        chk(gap, 40);
        @(posedge mclk);
        mm_n <= 1'b1;
        wr({8'h62, cfg_tail});
        @(posedge mclk);
        for (int g = 0; g < 12; g++) begin
            cell_voltage_codes[12*g +: 12] <= codes[g];
            fl[2*g +: 2] = {codes[g] > 12'h900, codes[g] < 12'h400};
        end
        tick_gap();
        rdchk(`SMF_CMD_RDFLG, 3, {fl[7:0], fl[15:8], fl[23:16]});
        wr({8'h6a, cfg_tail});
        rdchk(`SMF_CMD_RDFLG, 3, {fl[7:0], fl[15:8], 4'h0, fl[19:16]});
        wr({8'h60, cfg_tail});
        @(posedge mclk);
        cell_voltage_codes <= {12{12'h800}};
        repeat (60) @(posedge mclk);
        rdchk(`SMF_CMD_RDFLG, 3, {fl[7:0], fl[15:8], fl[23:16]});
        @(posedge mclk);
        ext1 <= 12'habc;
        ext2 <= 12'h123;
        intl <= 12'h9f5;
        temp_done <= 1'b1;
        hot_ev <= 1'b1;
        @(posedge mclk);
        temp_done <= 1'b0;
        repeat (4) @(posedge mclk);
        hot_ev <= 1'b0;
        repeat (4) @(posedge mclk);
        rdchk(`SMF_CMD_RDTMP, 5, {32'hbc3a12f5, revision_code, 5'h19});
        rdchk(`SMF_CMD_RDTMP, 5, {32'hbc3a12f5, revision_code, 5'h09});
        @(posedge mclk);
        {watch_pin, gp2, gp1} <= 3'b010;
        // an unknown command leaves the line alone
        i_host.frame(8'h0f, 48'h0, 0, 2, rd, oe);
        chk({rd[15:0], oe[15:0]}, 32'h0);
        // a short write is thrown away whole
        i_host.frame(`SMF_CMD_WRCFG, 48'h07ffff000000, 3, 0, rd, oe);
        rdchk(`SMF_CMD_RDCFG, 6, {8'h40, cfg_tail});
        report_and_stop();
    end
endmodule
